/* aisu_defs.vh */
`ifndef AISU_DEFS_VH
`define AISU_DEFS_VH

// Register indices; byte address is four times the index
`define AISU_IDX_IRQ_ENABLE   10'h0AC
`define AISU_IDX_ERROR_CAUSE  10'h0B2
`define AISU_IDX_EVENT_CAUSE  10'h0B3
`define AISU_IDX_CONFIG       10'h0C0
`define AISU_IDX_COMMAND      10'h0C1
`define AISU_IDX_EXT_STATUS   10'h0F1

// Writable bit masks
`define AISU_IRQ_ENABLE_MASK  32'h0003_7FFF
`define AISU_CONFIG_MASK      32'h0000_FFFF

// Reset values
`define AISU_IRQ_ENABLE_RST   32'h0000_0000
`define AISU_CONFIG_RST       32'h0000_0000

// Configuration field positions
`define AISU_CFG_CLEAR_MODE   0
`define AISU_CFG_HOMING_MODE  1
`define AISU_CFG_LATCH1_OFF   2
`define AISU_CFG_LATCH2_OFF   3
`define AISU_CFG_ORG_CNT1     4
`define AISU_CFG_ORG_CNT2     5
`define AISU_CFG_SD_ENABLE    6
`define AISU_CFG_SLM_LO       7
`define AISU_CFG_SLM_HI       8
`define AISU_CFG_INP_POL      9
`define AISU_CFG_TGT_POL      10
`define AISU_CFG_DEVCLR_POL   11
`define AISU_CFG_SW_POL       12
`define AISU_CFG_SD_POL       13
`define AISU_CFG_LTC_POL      14
`define AISU_CFG_ENC_2PULSE   15

// Command codes
`define AISU_CMD_EMERGENCY    8'h05
`define AISU_CMD_L3_ARM       8'h3C
`define AISU_CMD_L4_ARM       8'h3D
`define AISU_CMD_L3_DISARM    8'h3E
`define AISU_CMD_L4_DISARM    8'h3F

// Bus responses
`define AISU_RESP_OKAY        2'b00
`define AISU_RESP_SLVERR      2'b10

`endif

/* aisu_top.v */
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "aisu_defs.vh"

// Overview of operation
// - Enable 0,1 flag normal stop, pre-register free
// - Enable 2-5 flag acceleration/deceleration edges
// - Enable 6,7 flag comparator 1, 2 matches
// - Enable 8 flags latch, unless both off
// - Enable 9 flags origin, unless both clears zero
// - Enable 10 flags slow-down regardless of enable
// - Enable 11 flags switch change, pulser-select low
// - Enable 12-14 flag sync start, homing, start
// - Enable 16,17 flag latch 3, 4; reserved zero
// - Error causes clear on read or write-one
// - Event causes use the same clearing scheme
// - Error 0,1,3,5 limits, sync stop, slow-down
// - Error 2 alarm; error 4 emergency input/command
// - Error 6 on pulser buffer overflow stop
// - Error 7 on simultaneous encoder phase edges
// - Error 8 on simultaneous pulser rising edges
// - Error 9,10 soft limit stops, mode 1x
// - Event 14,15 soft limit detect, mode 01
// - Event bits 0-11 follow enable layout; bits 12-19 are shifted
// - Status bits 3..0 report run state
// - Input status bits apply selectable polarity, except fixed-inverted sync, emergency, Z pulse
// - Latch arm/captured flags by arm/disarm commands
// - Toggle flag inverts on latch value change
module aisu_top (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Event pulses from motion logic
  input  wire        ev_normal_stop,
  input  wire        ev_prereg_free,
  input  wire        ev_accel_start,
  input  wire        ev_accel_done,
  input  wire        ev_decel_start,
  input  wire        ev_decel_done,
  input  wire        ev_cmp1_met,
  input  wire        ev_cmp2_met,
  input  wire        ev_latch_cnt1,
  input  wire        ev_latch_cnt2,
  input  wire        ev_origin_on,
  input  wire        ev_decel_stop,
  input  wire        ev_start,
  input  wire        ev_latch3,
  input  wire        ev_latch4,
  input  wire        ev_soft_plus,
  input  wire        ev_soft_minus,
  // Stop cause pulses from motion logic
  input  wire        stop_plus_limit,
  input  wire        stop_minus_limit,
  input  wire        stop_alarm,
  input  wire        alarm_on_idle,
  input  wire        stop_sync_stop,
  input  wire        stop_slowdown,
  input  wire        stop_pulser_ovf,
  input  wire        stop_soft_plus,
  input  wire        stop_soft_minus,
  // Motion state
  input  wire [3:0]  run_state,
  input  wire        run_dir,
  input  wire [31:0] latch3_value,
  input  wire [31:0] latch4_value,
  // Asynchronous pins
  input  wire        plus_switch_in,
  input  wire        minus_switch_in,
  input  wire        pulser_axis_select,
  input  wire        sync_start_in,
  input  wire        sync_stop_in,
  input  wire        sync_decel_in,
  input  wire        emergency_in,
  input  wire        encoder_phase_a,
  input  wire        encoder_phase_b,
  input  wire        pulser_phase_a,
  input  wire        pulser_phase_b,
  input  wire        target_start_in,
  input  wire        dev_clear_in,
  input  wire        zpulse_in,
  input  wire        latch_in,
  input  wire        slowdown_in,
  input  wire        inposition_in,
  // Outputs to motion logic
  output reg         latch3_armed,
  output reg         latch4_armed,
  output reg         slowdown_enable,
  output reg         emergency_stop_cmd,
  output reg         irq
);

  // Pin synchroniser stages and previous value
  reg  [16:0] pin_meta;
  reg  [16:0] pin_sync;
  reg  [16:0] pin_prev;
  wire [16:0] pin_raw;

  // Software registers
  reg  [31:0] event_irq_enable;
  reg  [31:0] config_reg;
  reg  [10:0] error_cause;
  reg  [19:0] event_cause;
  reg         latch3_captured;
  reg         latch3_toggle;
  reg         latch4_captured;
  reg         latch4_toggle;
  reg  [31:0] latch3_prev;
  reg  [31:0] latch4_prev;

  // Next values
  reg  [10:0] next_error_cause;
  reg  [19:0] next_event_cause;
  reg  [10:0] err_set;
  reg  [19:0] evt_set;
  reg  [10:0] err_clr;
  reg  [19:0] evt_clr;
  reg  [31:0] rd_value;
  reg         rd_hit;
  reg         wr_hit;

  // Bus decode
  wire        wr_go;
  wire        rd_go;
  wire [9:0]  wr_idx;
  wire [9:0]  rd_idx;
  wire [31:0] wr_mask;
  wire [31:0] wr_bits;
  wire [7:0]  cmd_code;
  wire        cmd_wr;

  // Configuration fields
  wire        cause_clear_mode;
  wire        homing_stop_mode;
  wire        latch1_clear_off;
  wire        latch2_clear_off;
  wire        origin_clear_cnt1;
  wire        origin_clear_cnt2;
  wire [1:0]  soft_limit_mode;
  wire        inposition_polarity;
  wire        target_start_polarity;
  wire        dev_clear_polarity;
  wire        switch_polarity;
  wire        slowdown_polarity;
  wire        latch_in_polarity;
  wire        encoder_two_pulse;

  // Synchronised pin names
  wire        s_plus_sw;
  wire        s_minus_sw;
  wire        s_pulser_sel;
  wire        s_sync_start;
  wire        s_sync_stop;
  wire        s_sync_decel;
  wire        s_emerg;
  wire        s_enc_a;
  wire        s_enc_b;
  wire        s_pls_a;
  wire        s_pls_b;
  wire        s_tgt;
  wire        s_devclr;
  wire        s_zpulse;
  wire        s_latch;
  wire        s_sd;
  wire        s_inp;
  wire [16:0] pin_rise;
  wire [16:0] pin_fall;
  wire [16:0] pin_chg;

  // Derived event conditions
  wire        sd_active;
  wire        sd_active_prev;
  wire        latch_evt;
  wire        origin_evt;
  wire        switch_evt_p;
  wire        switch_evt_m;
  wire        enc_err;
  wire        pls_err;
  wire        l3_arm_cmd;
  wire        l4_arm_cmd;
  wire        latch3_disarm_cmd;
  wire        latch4_disarm_cmd;
  wire [22:0] ext_status;

  assign pin_raw = {inposition_in, slowdown_in, latch_in, zpulse_in,
                    dev_clear_in, target_start_in, pulser_phase_b,
                    pulser_phase_a, encoder_phase_b, encoder_phase_a,
                    emergency_in, sync_decel_in, sync_stop_in,
                    sync_start_in, pulser_axis_select, minus_switch_in,
                    plus_switch_in};

  assign s_plus_sw    = pin_sync[0];
  assign s_minus_sw   = pin_sync[1];
  assign s_pulser_sel = pin_sync[2];
  assign s_sync_start = pin_sync[3];
  assign s_sync_stop  = pin_sync[4];
  assign s_sync_decel = pin_sync[5];
  assign s_emerg      = pin_sync[6];
  assign s_enc_a      = pin_sync[7];
  assign s_enc_b      = pin_sync[8];
  assign s_pls_a      = pin_sync[9];
  assign s_pls_b      = pin_sync[10];
  assign s_tgt        = pin_sync[11];
  assign s_devclr     = pin_sync[12];
  assign s_zpulse     = pin_sync[13];
  assign s_latch      = pin_sync[14];
  assign s_sd         = pin_sync[15];
  assign s_inp        = pin_sync[16];

  // Edge detection works on the second stage only
  assign pin_rise = pin_sync & ~pin_prev;
  assign pin_fall = ~pin_sync & pin_prev;
  assign pin_chg  = pin_sync ^ pin_prev;

  assign cause_clear_mode      = config_reg[`AISU_CFG_CLEAR_MODE];
  assign homing_stop_mode      = config_reg[`AISU_CFG_HOMING_MODE];
  assign latch1_clear_off      = config_reg[`AISU_CFG_LATCH1_OFF];
  assign latch2_clear_off      = config_reg[`AISU_CFG_LATCH2_OFF];
  assign origin_clear_cnt1     = config_reg[`AISU_CFG_ORG_CNT1];
  assign origin_clear_cnt2     = config_reg[`AISU_CFG_ORG_CNT2];
  assign soft_limit_mode       = {config_reg[`AISU_CFG_SLM_HI],
                                  config_reg[`AISU_CFG_SLM_LO]};
  assign inposition_polarity   = config_reg[`AISU_CFG_INP_POL];
  assign target_start_polarity = config_reg[`AISU_CFG_TGT_POL];
  assign dev_clear_polarity    = config_reg[`AISU_CFG_DEVCLR_POL];
  assign switch_polarity       = config_reg[`AISU_CFG_SW_POL];
  assign slowdown_polarity     = config_reg[`AISU_CFG_SD_POL];
  assign latch_in_polarity     = config_reg[`AISU_CFG_LTC_POL];
  assign encoder_two_pulse     = config_reg[`AISU_CFG_ENC_2PULSE];

  // Slow-down active level with polarity; pin low is on for polarity 0
  assign sd_active      = s_sd ^ ~slowdown_polarity;
  assign sd_active_prev = pin_prev[15] ^ ~slowdown_polarity;

  // Latch on counters 1/2 counts unless both clear-offs set
  assign latch_evt = (ev_latch_cnt1 | ev_latch_cnt2) &
                     ~(latch1_clear_off & latch2_clear_off);
  // Origin turning on counts unless both origin clears are zero
  assign origin_evt = ev_origin_on &
                      (origin_clear_cnt1 | origin_clear_cnt2);
  // Switch changes are masked while the pulser select pin is high
  assign switch_evt_p = pin_chg[0] & ~s_pulser_sel;
  assign switch_evt_m = pin_chg[1] & ~s_pulser_sel;

  // Encoder error: both change in quadrature, both rise in two-pulse
  assign enc_err = encoder_two_pulse ? (pin_rise[7] & pin_rise[8])
                                     : (pin_chg[7] & pin_chg[8]);
  // Pulser error: both phases rise together
  assign pls_err = pin_rise[9] & pin_rise[10];

  // AXI write: address and data are taken together
  assign wr_go   = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready &
                   ~s_axi_bvalid;
  assign rd_go   = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  assign wr_idx  = s_axi_awaddr[11:2];
  assign rd_idx  = s_axi_araddr[11:2];
  assign wr_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign wr_bits = s_axi_wdata & wr_mask;
  assign cmd_code = s_axi_wdata[7:0];
  assign cmd_wr  = wr_go & (wr_idx == `AISU_IDX_COMMAND) & s_axi_wstrb[0];

  assign l3_arm_cmd        = cmd_wr & (cmd_code == `AISU_CMD_L3_ARM);
  assign l4_arm_cmd        = cmd_wr & (cmd_code == `AISU_CMD_L4_ARM);
  assign latch3_disarm_cmd = cmd_wr & (cmd_code == `AISU_CMD_L3_DISARM);
  assign latch4_disarm_cmd = cmd_wr & (cmd_code == `AISU_CMD_L4_DISARM);

  // Extended status word, input levels adjusted by polarity
  assign ext_status = {latch4_toggle, latch4_captured, latch4_armed,
                       latch3_toggle, latch3_captured, latch3_armed,
                       run_dir,
                       s_inp ^ ~inposition_polarity,
                       sd_active,
                       s_latch ^ ~latch_in_polarity,
                       s_minus_sw ^ ~switch_polarity,
                       s_plus_sw ^ ~switch_polarity,
                       ~s_zpulse,
                       s_devclr ^ ~dev_clear_polarity,
                       s_tgt ^ ~target_start_polarity,
                       ~s_emerg, ~s_sync_stop, ~s_sync_start,
                       ~s_sync_decel,
                       run_state};

  // Pin synchroniser, two flops then history for edges
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 17'h1_FFFF;
      pin_sync <= 17'h1_FFFF;
      pin_prev <= 17'h1_FFFF;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Hardware set terms for both cause registers
  always @* begin
    err_set     = 11'h000;
    err_set[0]  = stop_plus_limit;
    err_set[1]  = stop_minus_limit;
    err_set[2]  = stop_alarm | alarm_on_idle;
    err_set[3]  = stop_sync_stop;
    err_set[4]  = pin_fall[6] |
                  (cmd_wr & (cmd_code == `AISU_CMD_EMERGENCY));
    err_set[5]  = stop_slowdown;
    err_set[6]  = stop_pulser_ovf;
    err_set[7]  = enc_err;
    err_set[8]  = pls_err;
    err_set[9]  = stop_soft_plus & soft_limit_mode[1];
    err_set[10] = stop_soft_minus & soft_limit_mode[1];
    evt_set     = 20'h0_0000;
    // Enabled events only are recorded, except soft limit events 14,15
    evt_set[0]  = ev_normal_stop & event_irq_enable[0];
    evt_set[1]  = ev_prereg_free & event_irq_enable[1];
    evt_set[2]  = ev_accel_start & event_irq_enable[2];
    evt_set[3]  = ev_accel_done & event_irq_enable[3];
    evt_set[4]  = ev_decel_start & event_irq_enable[4];
    evt_set[5]  = ev_decel_done & event_irq_enable[5];
    evt_set[6]  = ev_cmp1_met & event_irq_enable[6];
    evt_set[7]  = ev_cmp2_met & event_irq_enable[7];
    evt_set[8]  = latch_evt & event_irq_enable[8];
    evt_set[9]  = origin_evt & event_irq_enable[9];
    // Slow-down turning on, independent of slow-down enable
    evt_set[10] = sd_active & ~sd_active_prev &
                  event_irq_enable[10];
    evt_set[11] = switch_evt_p & event_irq_enable[11];
    evt_set[12] = switch_evt_m & event_irq_enable[11];
    evt_set[13] = pin_fall[3] & event_irq_enable[12];
    evt_set[14] = ev_soft_plus & (soft_limit_mode == 2'b01);
    evt_set[15] = ev_soft_minus & (soft_limit_mode == 2'b01);
    evt_set[16] = ev_decel_stop & homing_stop_mode &
                  event_irq_enable[13];
    evt_set[17] = ev_start & event_irq_enable[14];
    evt_set[18] = ev_latch3 & event_irq_enable[16];
    evt_set[19] = ev_latch4 & event_irq_enable[17];
  end

  // Clear terms: whole register on read, or write-one per bit
  always @* begin
    err_clr = 11'h000;
    evt_clr = 20'h0_0000;
    if (!cause_clear_mode) begin
      if (rd_go && rd_idx == `AISU_IDX_ERROR_CAUSE)
        err_clr = 11'h7FF;
      if (rd_go && rd_idx == `AISU_IDX_EVENT_CAUSE)
        evt_clr = 20'hF_FFFF;
    end else begin
      if (wr_go && wr_idx == `AISU_IDX_ERROR_CAUSE)
        err_clr = wr_bits[10:0];
      if (wr_go && wr_idx == `AISU_IDX_EVENT_CAUSE)
        evt_clr = wr_bits[19:0];
    end
    // A new cause in the clearing cycle survives
    next_error_cause = (error_cause & ~err_clr) | err_set;
    next_event_cause = (event_cause & ~evt_clr) | evt_set;
  end

  // Read mux with decode flag
  always @* begin
    rd_value = 32'h0000_0000;
    rd_hit   = 1'b1;
    case (rd_idx)
      `AISU_IDX_IRQ_ENABLE:  rd_value = event_irq_enable;
      `AISU_IDX_ERROR_CAUSE: rd_value = {21'h00_0000, error_cause};
      `AISU_IDX_EVENT_CAUSE: rd_value = {12'h000, event_cause};
      `AISU_IDX_CONFIG:      rd_value = config_reg;
      `AISU_IDX_COMMAND:     rd_value = 32'h0000_0000;
      `AISU_IDX_EXT_STATUS:  rd_value = {9'h000, ext_status};
      default:               rd_hit   = 1'b0;
    endcase
  end

  // Write decode flag
  always @* begin
    case (wr_idx)
      `AISU_IDX_IRQ_ENABLE,
      `AISU_IDX_ERROR_CAUSE,
      `AISU_IDX_EVENT_CAUSE,
      `AISU_IDX_CONFIG,
      `AISU_IDX_COMMAND:     wr_hit = 1'b1;
      default:               wr_hit = 1'b0;
    endcase
  end

  // AXI write channel and writable registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready      <= 1'b0;
      s_axi_wready       <= 1'b0;
      s_axi_bvalid       <= 1'b0;
      s_axi_bresp        <= `AISU_RESP_OKAY;
      event_irq_enable   <= `AISU_IRQ_ENABLE_RST;
      config_reg         <= `AISU_CONFIG_RST;
      emergency_stop_cmd <= 1'b0;
      slowdown_enable    <= 1'b0;
    end else begin
      s_axi_awready      <= wr_go;
      s_axi_wready       <= wr_go;
      emergency_stop_cmd <= cmd_wr & (cmd_code == `AISU_CMD_EMERGENCY);
      slowdown_enable    <= config_reg[`AISU_CFG_SD_ENABLE];
      if (wr_go) begin
        // Response held until the master accepts it
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `AISU_RESP_OKAY : `AISU_RESP_SLVERR;
        if (wr_idx == `AISU_IDX_IRQ_ENABLE)
          // Reserved enable bits are stored as zero
          event_irq_enable <= ((event_irq_enable & ~wr_mask) | wr_bits)
                              & `AISU_IRQ_ENABLE_MASK;
        if (wr_idx == `AISU_IDX_CONFIG)
          config_reg <= ((config_reg & ~wr_mask) | wr_bits)
                        & `AISU_CONFIG_MASK;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AISU_RESP_OKAY;
    end else begin
      s_axi_arready <= rd_go;
      if (rd_go) begin
        // Data captured at the same edge as the read-clear
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_value;
        s_axi_rresp  <= rd_hit ? `AISU_RESP_OKAY : `AISU_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Cause registers and interrupt line
  always @(posedge aclk) begin
    if (!aresetn) begin
      error_cause <= 11'h000;
      event_cause <= 20'h0_0000;
      irq         <= 1'b0;
    end else begin
      error_cause <= next_error_cause;
      event_cause <= next_event_cause;
      irq <= (|next_error_cause) | (|next_event_cause);
    end
  end

  // Trigger latch 3 and 4 flags; capture wins over disarm
  always @(posedge aclk) begin
    if (!aresetn) begin
      latch3_armed    <= 1'b0;
      latch3_captured <= 1'b0;
      latch3_toggle   <= 1'b0;
      latch4_armed    <= 1'b0;
      latch4_captured <= 1'b0;
      latch4_toggle   <= 1'b0;
      latch3_prev     <= 32'h0000_0000;
      latch4_prev     <= 32'h0000_0000;
    end else begin
      latch3_prev <= latch3_value;
      latch4_prev <= latch4_value;
      if (l3_arm_cmd)
        latch3_armed <= 1'b1;
      else if (latch3_disarm_cmd)
        latch3_armed <= 1'b0;
      if (ev_latch3)
        latch3_captured <= 1'b1;
      else if (latch3_disarm_cmd)
        latch3_captured <= 1'b0;
      if (latch3_value != latch3_prev)
        latch3_toggle <= ~latch3_toggle;
      else if (latch3_disarm_cmd)
        latch3_toggle <= 1'b0;
      if (l4_arm_cmd)
        latch4_armed <= 1'b1;
      else if (latch4_disarm_cmd)
        latch4_armed <= 1'b0;
      if (ev_latch4)
        latch4_captured <= 1'b1;
      else if (latch4_disarm_cmd)
        latch4_captured <= 1'b0;
      if (latch4_value != latch4_prev)
        latch4_toggle <= ~latch4_toggle;
      else if (latch4_disarm_cmd)
        latch4_toggle <= 1'b0;
    end
  end

endmodule

/* aisu_chk.sv */
`timescale 1ns/1ns
module aisu_chk (
  // Clock, reset and bus handshakes
  input wire aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_awready,
  input wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire s_axi_rvalid, s_axi_rready,
  // Stop causes and request
  input wire stop_plus_limit, stop_alarm, stop_pulser_ovf, stop_slowdown, irq,
  input wire emergency_stop_cmd
);
  // All checks on the bus clock, quiet in reset
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Write taken with both channels, answered next cycle
  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid &&
    !s_axi_awready && !s_axi_bvalid |=> s_axi_bvalid && s_axi_awready)
    else $error("write not answered");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held");
  rd_answer_a: assert property (s_axi_arvalid && !s_axi_arready &&
    !s_axi_rvalid |=> s_axi_rvalid && s_axi_arready)
    else $error("read not answered");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held");
  // Stop causes always latch and raise the request
  limit_irq_a: assert property (stop_plus_limit |-> ##[1:2] irq)
    else $error("limit stop without request");
  alarm_irq_a: assert property (stop_alarm |-> ##[1:2] irq)
    else $error("alarm stop without request");
  ovf_irq_a: assert property (stop_pulser_ovf |-> ##[1:2] irq)
    else $error("overflow stop without request");
  sd_irq_a: assert property (stop_slowdown |-> ##[1:2] irq)
    else $error("slow-down stop without request");
  emg_cmd_a: assert property (emergency_stop_cmd |-> irq ##1
    !emergency_stop_cmd) else $error("emergency command not a pulse");
endmodule
bind aisu_top aisu_chk i_chk (.*);

/* aisu_host.sv */
`timescale 1ns/1ns
module aisu_host (
  // Clock
  input wire aclk,
  // Requests, changed just after a rising edge
  output logic [11:0] s_axi_awaddr, s_axi_araddr,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready,
  output logic s_axi_arvalid, s_axi_rready,
  // Answers from the register slave
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_bresp, s_axi_rresp,
  input wire s_axi_awready, s_axi_wready, s_axi_bvalid,
  input wire s_axi_arready, s_axi_rvalid
);
  // Idle bus at time zero
  initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid,
    s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  // Word write; each channel held until its own ready
  task automatic wr(input logic [9:0] idx, input logic [31:0] v,
    output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Word read; ready held until the data comes
  task automatic rd(input logic [9:0] idx, output logic [31:0] v,
    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {v, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
endmodule

/* axis_interrupt_status_unit_tb.sv */
`timescale 1ns/1ns
`include "aisu_defs.vh"
module axis_interrupt_status_unit_tb;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [16:0] ev = '0, pin = '1; // Event pulses, pin levels
  logic [8:0] st = '0; // Stop cause pulses
  logic [3:0] run_state = '0;
  logic [31:0] latch3_value = '0, d, e;
  logic [15:0] lfsr = 16'h000C; // Random source
  logic [1:0] r;
  int n_errors = 0, n_tests = 0;
  int eb[17] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 8, -1, -1, 17, 18, 19, -1, -1};
  wire [11:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    irq, latch3_armed, latch4_armed, slowdown_enable;
  aisu_host i_host (.*);
  aisu_top i_dut (.*, .ev_normal_stop(ev[0]), .ev_prereg_free(ev[1]),
    .ev_accel_start(ev[2]), .ev_accel_done(ev[3]), .ev_decel_start(ev[4]),
    .ev_decel_done(ev[5]), .ev_cmp1_met(ev[6]), .ev_cmp2_met(ev[7]),
    .ev_latch_cnt1(ev[8]), .ev_latch_cnt2(ev[9]), .ev_origin_on(ev[10]),
    .ev_decel_stop(ev[11]), .ev_start(ev[12]), .ev_latch3(ev[13]),
    .ev_latch4(ev[14]), .ev_soft_plus(ev[15]), .ev_soft_minus(ev[16]),
    .stop_plus_limit(st[0]), .stop_minus_limit(st[1]), .stop_alarm(st[2]),
    .alarm_on_idle(st[3]), .stop_sync_stop(st[4]), .stop_slowdown(st[5]),
    .stop_pulser_ovf(st[6]), .stop_soft_plus(st[7]), .stop_soft_minus(st[8]),
    .run_dir(lfsr[4]), .latch4_value(32'h0000_0000), .plus_switch_in(pin[0]),
    .minus_switch_in(pin[1]), .pulser_axis_select(pin[2]),
    .sync_start_in(pin[3]), .sync_stop_in(pin[4]), .sync_decel_in(pin[5]),
    .emergency_in(pin[6]), .encoder_phase_a(pin[7]), .encoder_phase_b(pin[8]),
    .pulser_phase_a(pin[9]), .pulser_phase_b(pin[10]),
    .target_start_in(pin[11]), .dev_clear_in(pin[12]), .zpulse_in(pin[13]),
    .latch_in(pin[14]), .slowdown_in(pin[15]), .inposition_in(pin[16]),
    .emergency_stop_cmd());
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #20 aclk = ~aclk;
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    n_errors++;
    finish_test;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    i_host.rd(`AISU_IDX_IRQ_ENABLE, d, r);
    chk("enable", d, 32'h0000_0000);
    i_host.wr(`AISU_IDX_IRQ_ENABLE, 32'hFFFF_FFFF, r);
    i_host.rd(`AISU_IDX_IRQ_ENABLE, d, r);
    chk("enable", d, 32'h0003_7FFF);
    i_host.rd(10'h001, d, r);
    chk("resp", r, 2'b10);
    $display("registers done");
    foreach (eb[i]) begin
      ev[i] <= 1'b1;
      @(posedge aclk);
      ev[i] <= 1'b0;
      repeat (2) @(posedge aclk);
      e = (eb[i] < 0) ? 0 : 32'h1 << eb[i];
      chk("irq", irq, e != 0);
      i_host.rd(`AISU_IDX_EVENT_CAUSE, d, r);
      chk("event", d, e);
      i_host.rd(`AISU_IDX_EVENT_CAUSE, d, r);
      chk("event", d, 0);
    end
    $display("events done");
    i_host.wr(`AISU_IDX_CONFIG, 32'h0000_0141, r);
    st <= 9'h1FF;
    @(posedge aclk);
    st <= 9'h000;
    for (int k = 0; k < 2; k++) begin
      i_host.rd(`AISU_IDX_ERROR_CAUSE, d, r);
      chk("error", d, 32'h0000_066F);
    end
    chk("sd_en", slowdown_enable, 1);
    i_host.wr(`AISU_IDX_ERROR_CAUSE, 32'h0000_000F, r);
    i_host.wr(`AISU_IDX_COMMAND, 32'h0000_0005, r);
    i_host.rd(`AISU_IDX_ERROR_CAUSE, d, r);
    chk("error", d, 32'h0000_0670);
    i_host.wr(`AISU_IDX_ERROR_CAUSE, 32'h0000_0670, r);
    i_host.rd(`AISU_IDX_ERROR_CAUSE, d, r);
    chk("irq", irq, 0);
    $display("errors done");
    i_host.wr(`AISU_IDX_COMMAND, 32'h0000_003C, r);
    i_host.wr(`AISU_IDX_COMMAND, 32'h0000_003D, r);
    lfsr = nx(lfsr);
    run_state <= lfsr[3:0];
    latch3_value <= {lfsr, lfsr};
    ev[13] <= 1'b1;
    @(posedge aclk);
    ev[13] <= 1'b0;
    i_host.rd(`AISU_IDX_EXT_STATUS, d, r);
    chk("status", d[20:16], {4'hF, lfsr[4]});
    chk("armed", {latch3_armed, latch4_armed}, 2'h3);
    chk("state", d[3:0], lfsr[3:0]);
    i_host.wr(`AISU_IDX_COMMAND, 32'h0000_003E, r);
    i_host.rd(`AISU_IDX_EXT_STATUS, d, r);
    chk("status", {latch3_armed, d[19:17]}, 4'h0);
    for (int k = 0; k < 2; k++) begin
      i_host.wr(`AISU_IDX_CONFIG, k << 12, r);
      lfsr = nx(lfsr);
      pin <= {lfsr, lfsr[0]};
      repeat (4) @(posedge aclk);
      i_host.rd(`AISU_IDX_EXT_STATUS, d, r);
      chk("switch", d[12:11], pin[1:0] ^ {2{!k}});
    end
    $display("status done");
    finish_test;
  end
endmodule
